//--- rtl/fpx_classify.sv
// Module: combinational operand classifier for single and double
`timescale 1ns/1ps
`default_nettype none
module fpx_classify (
    fpx_cls_if.rsp cif
);
    // Classify one operand; flush mode makes subnormals read as zero
    function automatic fpx_pkg::fpx_class_e cls_of(input logic [63:0] v,
            input logic d, input logic fz);
        logic [10:0] e;
        logic [51:0] m;
        logic        emax;
        e = d ? v[62:52] : {3'h0, v[30:23]};
        m = d ? v[51:0] : {29'h0, v[22:0]};
        emax = d ? (e == 11'h7FF) : (e[7:0] == 8'hFF);
        if (e == 11'h000)
            cls_of = (m == 52'h0 || fz) ? fpx_pkg::FPX_CL_ZERO
                                        : fpx_pkg::FPX_CL_SUB;
        else if (!emax)
            cls_of = fpx_pkg::FPX_CL_NORM;
        else if (m == 52'h0)
            cls_of = fpx_pkg::FPX_CL_INF;
        else if (d ? v[51] : v[22])
            cls_of = fpx_pkg::FPX_CL_QNAN;
        else
            cls_of = fpx_pkg::FPX_CL_SNAN;
    endfunction

    // A flushed subnormal counts as positive zero
    always_comb begin
        cif.cls_a  = cls_of(cif.op_a, cif.dbl, cif.flush_zero);
        cif.cls_b  = cls_of(cif.op_b, cif.dbl, cif.flush_zero);
        cif.sign_a = (cif.dbl ? cif.op_a[63] : cif.op_a[31])
                   && !(cif.flush_zero && cif.cls_a == fpx_pkg::FPX_CL_ZERO);
        cif.sign_b = (cif.dbl ? cif.op_b[63] : cif.op_b[31])
                   && !(cif.flush_zero && cif.cls_b == fpx_pkg::FPX_CL_ZERO);
        cif.exp_a  = cif.dbl ? {1'b0, cif.op_a[62:52]}
                             : {4'h0, cif.op_a[30:23]};
    end
endmodule : fpx_classify
`default_nettype wire

//--- rtl/fpx_cls_if.sv
// Interface: operand classification between detector and classifier
`timescale 1ns/1ps
`default_nettype none
interface fpx_cls_if;
    logic [63:0]       op_a;
    logic [63:0]       op_b;
    logic              dbl;
    logic              flush_zero;
    fpx_pkg::fpx_class_e cls_a;
    fpx_pkg::fpx_class_e cls_b;
    logic              sign_a;
    logic              sign_b;
    logic [11:0]       exp_a;
    modport req (output op_a, op_b, dbl, flush_zero,
                 input cls_a, cls_b, sign_a, sign_b, exp_a);
    modport rsp (input op_a, op_b, dbl, flush_zero,
                 output cls_a, cls_b, sign_a, sign_b, exp_a);
endinterface : fpx_cls_if
`default_nettype wire

//--- rtl/fpx_exc_unit.sv
// Module: invalid, division-by-zero and overflow exception unit
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Status bit 8 enables invalid trap; every invalid case then bounces.
// - With invalid trap on, any signalling NaN operand bounces; a MOVE with one does not.
// - Float-to-unsigned with negative input is potentially invalid and bounces.
// - Conversion at max exponent, rounding not toward zero, bounces.
// - MAC with infinite addend and possible opposing product overflow bounces.
// - Potential invalid sets exception-register bits 31 and 0.
// - Invalid bounce keeps source and destination registers valid.
// - Invalid trap off: default NaN written, except integer conversions.
// - Invalid conversion, trap off: default integer written, status bit 0 set.
// - Unsigned: big or +inf all ones; negative, NaN, -inf zero. The code bounces negative and -inf inputs instead of writing zero.
// - Signed: big/+inf max; small/-inf 0x80000000; NaN zero; flag set.
// - Default-NaN mode off: signalling NaN sets invalid and bounces.
// - Negative unsigned input not rounding to true zero sets register bit 0.
// - Finite nonzero divided by zero raises division by zero; flushed subnormal zero.
// - Division trap at status bit 9: bounce, registers unchanged.
// - Division trap off: signed infinity written, status bit 1 set.
// - Overflow trap at bit 10: pessimistic detection; else conclusive.
// - Trap on: bounce when initial exponent is max or max minus one.
// - Potential overflow sets bits 31 and 2; status overflow flag untouched.
// - Trap off: infinity or max finite by rounding; status bits 2, 4 set.
// - Untrapped overflow, round to nearest: infinity with intermediate sign.
// - Toward zero max magnitude; directed modes pick infinity or max per sign.
module fpx_exc_unit (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        instr_valid,
    input  wire logic [2:0]  instr_op,
    input  wire logic        instr_dbl,
    input  wire logic [63:0] operand_a,
    input  wire logic [63:0] operand_b,
    input  wire logic [63:0] result_in,
    input  wire logic        res_sign,
    input  wire logic [11:0] res_exp,
    input  wire logic        res_ovf,
    input  wire logic        mac_prod_ovf,
    input  wire logic        conv_neg_nonzero,
    input  wire logic        conv_out_of_range,
    input  wire logic [31:0] conv_int,
    input  wire logic        scw_write,
    input  wire logic [31:0] scw_wdata,
    input  wire logic        exr_write,
    input  wire logic [31:0] exr_wdata,
    output logic             instr_ready,
    output logic             wr_valid,
    output logic [63:0]      wr_data,
    output logic             bounce,
    output logic [31:0]      fp_status_control_word,
    output logic [31:0]      fp_exception_register
);
    fpx_cls_if cif ();
    fpx_classify u_cls (.cif(cif));

    // Event decision for the current instruction
    fpx_pkg::fpx_op_e    op;
    fpx_pkg::fpx_rmode_e rm;
    logic        inv_en;
    logic        dz_en;
    logic        of_en;
    logic        dnan;
    logic        conv;

    logic        any_nan;
    logic        any_snan;
    logic        inv_hard;
    logic        inv_pot;
    logic        dz_hit;
    logic        of_hit;
    logic        of_pot;

    logic [11:0] emax;
    logic [11:0] econv;
    logic [31:0] def_int;
    logic [63:0] inf_v;
    logic [63:0] maxf_v;
    logic [63:0] sign_v;

    // Sequencer state and next values
    fpx_pkg::fpx_state_e state;
    fpx_pkg::fpx_state_e next_state;
    logic [31:0] next_scw;
    logic [31:0] next_exr;
    logic        next_wr_valid;
    logic [63:0] next_wr_data;
    logic        next_bounce;
    logic        next_ready;

    // Classifier sees the raw operands and the flush mode
    assign cif.op_a       = operand_a;
    assign cif.op_b       = operand_b;
    assign cif.dbl        = instr_dbl;
    assign cif.flush_zero = fp_status_control_word[fpx_pkg::SCW_FLUSH_ZERO];

    // Pick single or double constant
    function automatic logic [63:0] by_size(input logic d,
            input logic [63:0] s, input logic [63:0] dv);
        by_size = d ? dv : s;
    endfunction

    // Field decode and invalid classification
    always_comb begin
        op     = fpx_pkg::fpx_op_e'(instr_op);
        rm     = fpx_pkg::fpx_rmode_e'(
                 fp_status_control_word[fpx_pkg::SCW_RMODE_LO +: 2]);
        inv_en = fp_status_control_word[fpx_pkg::SCW_INV_EN];
        dz_en  = fp_status_control_word[fpx_pkg::SCW_DZ_EN];
        of_en  = fp_status_control_word[fpx_pkg::SCW_OF_EN];
        dnan   = fp_status_control_word[fpx_pkg::SCW_DEF_NAN];
        conv   = (op == fpx_pkg::FPX_OP_TOU) || (op == fpx_pkg::FPX_OP_TOS);
        emax   = instr_dbl ? fpx_pkg::EMAX_D : fpx_pkg::EMAX_S;
        // Limit exponent is unbiased, the operand's is stored biased
        econv  = ((op == fpx_pkg::FPX_OP_TOU) ? fpx_pkg::ECONV_U
                                              : fpx_pkg::ECONV_S)
               + (instr_dbl ? fpx_pkg::BIAS_D : fpx_pkg::BIAS_S);
        inf_v  = by_size(instr_dbl, fpx_pkg::INF_S, fpx_pkg::INF_D);
        maxf_v = by_size(instr_dbl, fpx_pkg::MAXF_S, fpx_pkg::MAXF_D);
        sign_v = by_size(instr_dbl, fpx_pkg::SIGN_S, fpx_pkg::SIGN_D);
        any_snan = (cif.cls_a == fpx_pkg::FPX_CL_SNAN)
                 || (!conv && cif.cls_b == fpx_pkg::FPX_CL_SNAN);
        any_nan  = any_snan || (cif.cls_a == fpx_pkg::FPX_CL_QNAN)
                 || (!conv && cif.cls_b == fpx_pkg::FPX_CL_QNAN);

        // Conclusive invalid: SNaN in arithmetic, 0/0, inf/inf
        inv_hard = (op != fpx_pkg::FPX_OP_MOVE) && any_snan;
        if (op == fpx_pkg::FPX_OP_DIV)
            inv_hard = inv_hard
                || (cif.cls_a == fpx_pkg::FPX_CL_ZERO
                    && cif.cls_b == fpx_pkg::FPX_CL_ZERO)
                || (cif.cls_a == fpx_pkg::FPX_CL_INF
                    && cif.cls_b == fpx_pkg::FPX_CL_INF);

        // Potential invalid: needs rounding knowledge not yet available
        inv_pot = 1'b0;
        if (op == fpx_pkg::FPX_OP_TOU && cif.sign_a && !any_nan)
            inv_pot = 1'b1;
        if (conv && cif.exp_a == econv && rm != fpx_pkg::FPX_RZ)
            inv_pot = 1'b1;
        if (op == fpx_pkg::FPX_OP_MAC && cif.cls_b == fpx_pkg::FPX_CL_INF
            && mac_prod_ovf && (res_sign != cif.sign_b))
            inv_pot = 1'b1;

        // Division of finite nonzero by zero
        dz_hit = (op == fpx_pkg::FPX_OP_DIV)
               && (cif.cls_a == fpx_pkg::FPX_CL_NORM
                   || cif.cls_a == fpx_pkg::FPX_CL_SUB)
               && cif.cls_b == fpx_pkg::FPX_CL_ZERO;

        // Pessimistic window versus conclusive overflow
        // Max or max-1 may still overflow once rounding carries
        of_pot = !conv && (op != fpx_pkg::FPX_OP_MOVE)
               && (res_exp == emax || res_exp == emax - 12'h001);
        of_hit = !conv && (op != fpx_pkg::FPX_OP_MOVE) && res_ovf;
    end

    // Default integer result for an invalid conversion
    always_comb begin
        def_int = conv_int;
        if (op == fpx_pkg::FPX_OP_TOU) begin
            // Unsigned: NaN or negative gives zero
            if (cif.cls_a == fpx_pkg::FPX_CL_QNAN
                || cif.cls_a == fpx_pkg::FPX_CL_SNAN || cif.sign_a)
                def_int = fpx_pkg::INT_ZERO;
            else if (conv_out_of_range)
                def_int = fpx_pkg::UINT_MAX;
        end else begin
            // Signed: out of range saturates by sign
            if (cif.cls_a == fpx_pkg::FPX_CL_QNAN
                || cif.cls_a == fpx_pkg::FPX_CL_SNAN)
                def_int = fpx_pkg::INT_ZERO;
            else if (conv_out_of_range)
                def_int = cif.sign_a ? fpx_pkg::SINT_MIN
                                     : fpx_pkg::SINT_MAX;
        end
    end

    // Instruction sequencing and flag updates
    always_comb begin
        next_state    = state;
        next_scw      = fp_status_control_word;
        next_exr      = fp_exception_register;
        next_wr_valid = 1'b0;
        next_wr_data  = result_in;
        next_bounce   = 1'b0;
        // Software write replaces the word, hardware sets go on top
        if (scw_write)
            next_scw = scw_wdata;
        if (exr_write)
            next_exr = exr_wdata;

        // One instruction in flight; HALT waits for software
        case (state)
            fpx_pkg::FPX_IDLE: begin
                if (instr_valid) begin
                    next_state = fpx_pkg::FPX_DONE;
                    if (inv_pot || (inv_hard && (inv_en || !dnan))
                        || (conv && inv_en
                            && (any_nan || conv_out_of_range))) begin
                        // Bounce: no write, registers keep their values
                        next_bounce = 1'b1;
                        next_state  = fpx_pkg::FPX_HALT;
                        next_exr[fpx_pkg::EXR_EXC_STATE] = 1'b1;
                        next_exr[fpx_pkg::EXR_INV_FLAG]  = 1'b1;
                        // Status invalid flag left for support code
                    end else if (conv) begin
                        next_wr_valid = 1'b1;
                        next_wr_data  = {fpx_pkg::WORD_ZERO, def_int};
                        if (any_nan || conv_out_of_range
                            || (op == fpx_pkg::FPX_OP_TOU
                                && conv_neg_nonzero))
                            next_scw[fpx_pkg::SCW_INV_FLAG] = 1'b1;
                    end else if (inv_hard) begin
                        next_wr_valid = 1'b1;
                        next_wr_data  = by_size(instr_dbl, fpx_pkg::DNAN_S,
                                                fpx_pkg::DNAN_D);
                        next_scw[fpx_pkg::SCW_INV_FLAG] = 1'b1;
                    end else if (dz_hit && dz_en) begin
                        next_bounce = 1'b1;
                        next_state  = fpx_pkg::FPX_HALT;
                        next_exr[fpx_pkg::EXR_EXC_STATE] = 1'b1;
                    end else if (dz_hit) begin
                        next_wr_valid = 1'b1;
                        next_wr_data  = inf_v
                            | ((cif.sign_a ^ cif.sign_b) ? sign_v
                                                         : 64'h0);
                        next_scw[fpx_pkg::SCW_DZ_FLAG] = 1'b1;
                    end else if (of_en && (of_pot || of_hit)) begin
                        next_bounce = 1'b1;
                        next_state  = fpx_pkg::FPX_HALT;
                        next_exr[fpx_pkg::EXR_EXC_STATE] = 1'b1;
                        next_exr[fpx_pkg::EXR_OF_FLAG]   = 1'b1;
                    end else if (of_hit) begin
                        next_wr_valid = 1'b1;
                        case (rm)
                            fpx_pkg::FPX_RN:
                                next_wr_data = inf_v;
                            fpx_pkg::FPX_RZ:
                                next_wr_data = maxf_v;
                            fpx_pkg::FPX_RP:
                                next_wr_data = res_sign ? maxf_v
                                                        : inf_v;
                            fpx_pkg::FPX_RM:
                                next_wr_data = res_sign ? inf_v
                                                        : maxf_v;
                            default:
                                next_wr_data = inf_v;
                        endcase
                        if (res_sign)
                            next_wr_data = next_wr_data | sign_v;
                        next_scw[fpx_pkg::SCW_OF_FLAG] = 1'b1;
                        next_scw[fpx_pkg::SCW_IX_FLAG] = 1'b1;
                    end else begin
                        next_wr_valid = 1'b1;
                    end
                end
            end
            fpx_pkg::FPX_DONE: begin
                next_state = fpx_pkg::FPX_IDLE;
            end
            fpx_pkg::FPX_HALT: begin
                // Held until software drops the exceptional state
                if (!next_exr[fpx_pkg::EXR_EXC_STATE])
                    next_state = fpx_pkg::FPX_IDLE;
            end
            default: begin
                next_state = fpx_pkg::FPX_IDLE;
            end
        endcase

        // Ready is registered, so it drops the cycle after a take
        next_ready = (next_state == fpx_pkg::FPX_IDLE);
    end

    // State and outputs registered
    always_ff @(posedge clk_sys) begin
        // Ready rises in reset: the first offer needs no wait
        if (reset) begin
            state                  <= fpx_pkg::FPX_IDLE;
            fp_status_control_word <= fpx_pkg::WORD_ZERO;
            fp_exception_register  <= fpx_pkg::WORD_ZERO;
            wr_valid               <= 1'b0;
            wr_data                <= 64'h0;
            bounce                 <= 1'b0;
            instr_ready            <= 1'b1;
        end else begin
            state                  <= next_state;
            fp_status_control_word <= next_scw;
            fp_exception_register  <= next_exr;
            wr_valid               <= next_wr_valid;
            wr_data                <= next_wr_data;
            bounce                 <= next_bounce;
            instr_ready            <= next_ready;
        end
    end
endmodule : fpx_exc_unit
`default_nettype wire

//--- rtl/fpx_pkg.sv
// Package: constants and types for the FP exception unit
package fpx_pkg;
    // Status/control word bit positions
    localparam int SCW_INV_FLAG   = 0;
    localparam int SCW_DZ_FLAG    = 1;
    localparam int SCW_OF_FLAG    = 2;
    localparam int SCW_IX_FLAG    = 4;
    localparam int SCW_INV_EN     = 8;
    localparam int SCW_DZ_EN      = 9;
    localparam int SCW_OF_EN      = 10;
    localparam int SCW_DEF_NAN    = 25;
    localparam int SCW_FLUSH_ZERO = 24;
    localparam int SCW_RMODE_LO   = 22;
    // Exception register bit positions
    localparam int EXR_INV_FLAG   = 0;
    localparam int EXR_OF_FLAG    = 2;
    localparam int EXR_EXC_STATE  = 31;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    // Default integer results
    localparam logic [31:0] UINT_MAX  = 32'hFFFF_FFFF;
    localparam logic [31:0] SINT_MAX  = 32'h7FFF_FFFF;
    localparam logic [31:0] SINT_MIN  = 32'h8000_0000;
    localparam logic [31:0] INT_ZERO  = 32'h0000_0000;
    // Default values for single and double
    localparam logic [63:0] DNAN_S    = 64'h0000_0000_7FC0_0000;
    localparam logic [63:0] DNAN_D    = 64'h7FF8_0000_0000_0000;
    localparam logic [63:0] INF_S     = 64'h0000_0000_7F80_0000;
    localparam logic [63:0] INF_D     = 64'h7FF0_0000_0000_0000;
    localparam logic [63:0] MAXF_S    = 64'h0000_0000_7F7F_FFFF;
    localparam logic [63:0] MAXF_D    = 64'h7FEF_FFFF_FFFF_FFFF;
    localparam logic [63:0] SIGN_S    = 64'h0000_0000_8000_0000;
    localparam logic [63:0] SIGN_D    = 64'h8000_0000_0000_0000;
    // Maximum biased exponents, and exponent that holds integer limit
    localparam logic [11:0] EMAX_S    = 12'h0FE;
    localparam logic [11:0] EMAX_D    = 12'h7FE;
    localparam logic [11:0] ECONV_U   = 12'h01F;
    localparam logic [11:0] ECONV_S   = 12'h01E;
    // Exponent biases, to compare an integer limit with a stored exponent
    localparam logic [11:0] BIAS_S    = 12'h07F;
    localparam logic [11:0] BIAS_D    = 12'h3FF;
    // Rounding modes
    typedef enum logic [1:0] {
        FPX_RN = 2'h0, FPX_RP = 2'h1, FPX_RM = 2'h2, FPX_RZ = 2'h3
    } fpx_rmode_e;
    // Operation classes
    typedef enum logic [2:0] {
        FPX_OP_ARITH = 3'h0, FPX_OP_DIV = 3'h1, FPX_OP_MAC = 3'h2,
        FPX_OP_TOU = 3'h3, FPX_OP_TOS = 3'h4, FPX_OP_MOVE = 3'h5
    } fpx_op_e;
    // Operand class codes
    typedef enum logic [2:0] {
        FPX_CL_ZERO = 3'h0, FPX_CL_SUB = 3'h1, FPX_CL_NORM = 3'h2,
        FPX_CL_INF = 3'h3, FPX_CL_QNAN = 3'h4, FPX_CL_SNAN = 3'h5
    } fpx_class_e;
    // Engine states
    typedef enum logic [2:0] {
        FPX_IDLE = 3'b001, FPX_DONE = 3'b010, FPX_HALT = 3'b100
    } fpx_state_e;
endpackage : fpx_pkg

//--- verification/fpx_exc_properties.sv
// Checker: port-level properties of the FP exception unit
`timescale 1ns/1ps
`default_nettype none
module fpx_exc_properties (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        instr_valid,
    input wire logic        instr_ready,
    input wire logic        scw_write,
    input wire logic        exr_write,
    input wire logic        wr_valid,
    input wire logic        bounce,
    input wire logic [31:0] fp_status_control_word,
    input wire logic [31:0] fp_exception_register
);
    // One clock domain, so clocking and disable are shared
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    // A bounce never writes the destination, and each take answers once
    a_answer_once: assert property (instr_valid && instr_ready |=> wr_valid ^ bounce)
        else $error("take not answered by exactly one write or bounce");
    a_bounce_exc: assert property (bounce |-> fp_exception_register[31])
        else $error("bounce without exceptional state");
    a_exc_holds: assert property (fp_exception_register[31] |-> !instr_ready)
        else $error("ready while exceptional state set");
    a_exc_clear: assert property ($fell(fp_exception_register[31]) |-> $past(exr_write))
        else $error("exceptional state cleared without software write");
    a_inv_kept: assert property (bounce && !$past(scw_write) |-> $stable(fp_status_control_word[0]))
        else $error("status invalid flag moved on bounce");
    a_flags_sticky: assert property ((|($past(fp_status_control_word) & ~fp_status_control_word & 32'h0000_0017)) |-> $past(scw_write))
        else $error("status flag cleared without software write");
    a_of_trap_quiet: assert property ($rose(fp_status_control_word[2]) && !$past(scw_write) |-> !$past(fp_status_control_word[10]))
        else $error("status overflow set while trap enabled");
    a_of_inexact: assert property ($rose(fp_status_control_word[2]) && !$past(scw_write) |-> fp_status_control_word[4])
        else $error("overflow flag without inexact flag");
    // Main scenarios reached
    c_bounce: cover property (bounce);
    c_of_write: cover property (wr_valid && fp_status_control_word[2]);
    c_exc_clear: cover property ($fell(fp_exception_register[31]));
endmodule // fpx_exc_properties
bind fpx_exc_unit fpx_exc_properties u_props (.clk_sys(clk_sys),
    .reset(reset), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .scw_write(scw_write), .exr_write(exr_write), .wr_valid(wr_valid),
    .bounce(bounce), .fp_status_control_word(fp_status_control_word),
    .fp_exception_register(fp_exception_register));
`default_nettype wire

//--- verification/fpx_host_model.sv
// Partner model: host support code that clears the exceptional state
`timescale 1ns/1ps
`default_nettype none
module fpx_host_model #(
    parameter int DELAY = 4
) (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        bounce,
    output var  logic        exr_write,
    output var  logic [31:0] exr_wdata
);
    // Writing zero drops the exceptional state and the register's flags
    assign exr_wdata = 32'h0000_0000;
    // Handling takes DELAY cycles, so the unit must hold off meanwhile
    always begin
        @(posedge clk_sys);
        if (reset) begin
            exr_write <= 1'b0;
        end else if (bounce === 1'b1) begin
            repeat (DELAY) @(posedge clk_sys);
            exr_write <= 1'b1;
            @(posedge clk_sys);
            exr_write <= 1'b0;
        end
    end
endmodule // fpx_host_model
`default_nettype wire

//--- verification/testbench.sv
// Testbench: directed scenarios for the FP exception unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk_sys, reset, instr_valid, instr_dbl, res_sign, res_ovf;
    logic        mac_prod_ovf, conv_neg_nonzero, conv_out_of_range;
    logic        scw_write, exr_write, instr_ready, wr_valid, bounce;
    logic [2:0]  instr_op;
    logic [11:0] res_exp;
    logic [31:0] conv_int, scw_wdata, exr_wdata, scw, exr;
    logic [63:0] operand_a, operand_b, result_in, wr_data;
    int          miscompares = 0;
    int          n_compared = 0;
    fpx_exc_unit dut (
        .clk_sys(clk_sys), .reset(reset), .instr_valid(instr_valid),
        .instr_op(instr_op), .instr_dbl(instr_dbl), .operand_a(operand_a),
        .operand_b(operand_b), .result_in(result_in), .res_sign(res_sign),
        .res_exp(res_exp), .res_ovf(res_ovf), .mac_prod_ovf(mac_prod_ovf),
        .conv_neg_nonzero(conv_neg_nonzero), .conv_int(conv_int),
        .conv_out_of_range(conv_out_of_range), .scw_write(scw_write),
        .scw_wdata(scw_wdata), .exr_write(exr_write), .exr_wdata(exr_wdata),
        .instr_ready(instr_ready), .wr_valid(wr_valid), .wr_data(wr_data),
        .bounce(bounce), .fp_status_control_word(scw),
        .fp_exception_register(exr));
    fpx_host_model #(.DELAY(4)) host (.clk_sys(clk_sys), .reset(reset),
        .bounce(bounce), .exr_write(exr_write), .exr_wdata(exr_wdata));
    // 50 MHz pipeline clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic chk(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wscw(input logic [31:0] d);
        @(posedge clk_sys);
        scw_write <= 1'b1;
        scw_wdata <= d;
        @(posedge clk_sys);
        scw_write <= 1'b0;
    endtask
    // Waits for ready, offers one instruction, then judges the answer kind
    task automatic issue(input logic [2:0] op, input logic [63:0] a,
        input logic [63:0] b, input logic [3:0] f, input logic [11:0] x,
        input logic eb);
        int n;
        n = 0;
        do @(posedge clk_sys); while (instr_ready !== 1'b1 && ++n < 60);
        if (instr_ready !== 1'b1) miscompares++;
        instr_op <= op;
        operand_a <= a;
        operand_b <= b;
        {res_ovf, res_sign, conv_out_of_range, conv_neg_nonzero} <= f;
        res_exp <= x;
        instr_valid <= 1'b1;
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        #1;
        chk("answer", {62'h0, eb, !eb}, {62'h0, bounce, wr_valid});
    endtask
    task automatic t_conv();
        logic [2:0]  op [6] = '{3'h3, 3'h3, 3'h3, 3'h4, 3'h4, 3'h4};
        logic [63:0] a [6] = '{64'h7F800000, 64'h7FC00000, 64'h3F800000,
                              64'h7F800000, 64'hFF800000, 64'h7FC00000};
        logic [31:0] e [6] = '{32'hFFFFFFFF, 32'h0, 32'h1,
                              32'h7FFFFFFF, 32'h80000000, 32'h0};
        for (int i = 0; i < 6; i++) begin
            wscw(32'h0);
            issue(op[i], a[i], 64'h0, {2'b00, i != 2, 1'b0}, 12'h080, 1'b0);
            chk("conv result", {32'h0, e[i]}, {32'h0, wr_data[31:0]});
            chk("conv flag", {63'h0, i != 2}, {63'h0, scw[0]});
        end
        $display("test conversions done");
    endtask
    task automatic t_inv();
        wscw(32'h0000_0100);
        issue(3'h0, 64'h7F800001, 64'h0, 4'h0, 12'h080, 1'b1);
        chk("exc reg", 64'h80000001, {32'h0, exr});
        chk("inv status", 64'h0, {63'h0, scw[0]});
        issue(3'h3, 64'hBF800000, 64'h0, 4'h1, 12'h080, 1'b1);
        chk("neg conv exc", 64'h80000001, {32'h0, exr});
        issue(3'h4, 64'h7FC00000, 64'h0, 4'h0, 12'h080, 1'b1);
        wscw(32'h0);
        issue(3'h0, 64'h7F800001, 64'h0, 4'h0, 12'h080, 1'b1);
        issue(3'h4, 64'h4E800000, 64'h0, 4'h0, 12'h080, 1'b1);
        mac_prod_ovf <= 1'b1;
        issue(3'h2, 64'h3F800000, 64'h7F800000, 4'h4, 12'h080, 1'b1);
        mac_prod_ovf <= 1'b0;
        chk("mac exc", 64'h80000001, {32'h0, exr});
        wscw(32'h0200_0000);
        issue(3'h0, 64'h7F800001, 64'h0, 4'h0, 12'h080, 1'b0);
        chk("default nan", 64'h7FC00000, wr_data);
        $display("test invalid done");
    endtask
    task automatic t_div();
        wscw(32'h0);
        issue(3'h1, 64'hBF800000, 64'h0, 4'h0, 12'h080, 1'b0);
        chk("dz result", 64'hFF800000, wr_data);
        chk("dz flag", 64'h1, {63'h0, scw[1]});
        wscw(32'h0000_0200);
        issue(3'h1, 64'h3F800000, 64'h0, 4'h0, 12'h080, 1'b1);
        chk("dz exc", 64'h1, {63'h0, exr[31]});
        $display("test division done");
    endtask
    // Every rounding mode with both signs, then a trapped near-overflow
    task automatic t_ovf();
        logic inf;
        for (int m = 0; m < 8; m++) begin
            inf = m[2:1] == 0 || (m[2:1] == 1 && !m[0]) || (m[2:1] == 2 && m[0]);
            wscw({8'h0, m[2:1], 22'h0});
            issue(3'h0, 64'h3F800000, 64'h3F800000, {1'b1, m[0], 2'b00},
                  12'h0FF, 1'b0);
            chk("ovf result", {32'h0, m[0], inf ? 31'h7F800000 : 31'h7F7FFFFF},
                wr_data);
            chk("ovf flags", 64'h3, {62'h0, scw[4], scw[2]});
        end
        wscw(32'h0000_0400);
        issue(3'h0, 64'h3F800000, 64'h3F800000, 4'h0, 12'h0FD, 1'b1);
        chk("ovf exc", 64'h3, {62'h0, exr[31], exr[2]});
        chk("ovf status", 64'h0, {63'h0, scw[2]});
        $display("test overflow done");
    endtask
    // Main sequence: quiet inputs, reset, scenarios
    initial begin
        {instr_valid, instr_dbl, instr_op, res_sign, res_ovf} = '0;
        {mac_prod_ovf, conv_neg_nonzero, conv_out_of_range} = '0;
        {scw_write, scw_wdata, operand_a, operand_b} = '0;
        res_exp = 12'h080;
        conv_int = 32'h0000_0001;
        result_in = 64'h3F800000;
        reset = 1'b1;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        t_conv();
        t_inv();
        t_div();
        t_ovf();
        finish_test();
    end
    // Watchdog: the scenarios need well under a thousand cycles
    initial begin
        #100us;
        miscompares++;
        finish_test();
    end
endmodule // testbench
`default_nettype wire
